// >>> hdl/istc_pkg.sv
// package for the idle and standby timer block
package istc_pkg;
    localparam logic [7:0] CMD_IDLE      = 8'he3;
    localparam logic [7:0] CMD_IDLE_IMM  = 8'he1;
    localparam logic [7:0] CODE_OFF      = 8'h00;
    localparam logic [7:0] CODE_SEC_MAX  = 8'hf0;
    localparam logic [7:0] CODE_HALF_MAX = 8'hfb;
    localparam logic [7:0] CODE_21M      = 8'hfc;
    localparam logic [7:0] CODE_8H       = 8'hfd;
    localparam logic [7:0] CODE_RSVD     = 8'hfe;
    localparam logic [7:0] CODE_21M15S   = 8'hff;
    localparam int CLK_HZ         = 50000000;
    localparam int SEC_UNIT_S     = 5;
    localparam int HALF_UNIT_S    = 1800;
    localparam int MIN21_S        = 1260;
    localparam int HOUR8_S        = 28800;
    localparam int MIN21S15_S     = 1275;
    localparam int DEFAULT_S      = 60;
    localparam int HALF_BASE      = 240;
    localparam int SEC_TICK_CYC   = CLK_HZ;
    localparam logic [15:0] UNITS_21M     = 16'(MIN21_S);
    localparam logic [15:0] UNITS_8H      = 16'(HOUR8_S);
    localparam logic [15:0] UNITS_21M15S  = 16'(MIN21S15_S);
    localparam logic [15:0] UNITS_DEFAULT = 16'(DEFAULT_S);

    typedef enum logic [2:0] {
        ISTC_ACTIVE  = 3'b001,
        ISTC_IDLE    = 3'b010,
        ISTC_STANDBY = 3'b100
    } istc_mode_type;

    typedef struct packed {
        logic       valid;
        logic [7:0] opcode;
        logic [7:0] count;
    } istc_cmd_type;

    typedef struct packed {
        logic busy;
        logic intrq;
        logic spinup;
        logic standby_req;
    } istc_resp_type;
endpackage

// >>> hdl/istc_top.sv
// idle and idle immediate command handling with standby countdown
//
// Functional notes
// RQ1: idle command enters idle mode, clears busy, pulses completion interrupt.
// RQ2: completion interrupt is raised at once, not after idle transition.
// RQ3: spin-up request is skipped when the spindle already rotates.
// RQ4: nonzero count enables standby timer which starts counting at once.
// RQ5: zero count disables the automatic standby timeout.
// RQ6: timer expiry while idle requests standby; one minute default.
// RQ7: codes 1 to 240 give code times five seconds.
// RQ8: codes 241 to 251 give code minus 240 times thirty minutes.
// RQ9: fch 21 min, fdh 8 h, ffh 21 min 15 s; feh reserved.
// RQ10: idle immediate enters idle mode, clears busy, pulses interrupt.
// RQ11: every idle command reloads the timer, dropping any running count.
`timescale 1ns/1ps
`default_nettype none
module istc_top
#(
    parameter int TICK_CYC = istc_pkg::SEC_TICK_CYC
) (
    input  wire logic          core_clk,
    input  wire logic          rst_b,
    input  wire istc_pkg::istc_cmd_type cmd,
    input  wire logic          spindle_on,
    input  wire logic          standby_ack,
    output istc_pkg::istc_resp_type resp,
    output istc_pkg::istc_mode_type mode
);
    import istc_pkg::*;

    localparam int TW = $clog2(TICK_CYC + 1);

    istc_mode_type mode_q, mode_d;
    logic [15:0]   secs_q, secs_d;
    logic [TW-1:0] tick_q, tick_d;
    logic          run_q, run_d;
    logic          busy_q, busy_d;
    logic          irq_q, irq_d;
    logic          spin_q, spin_d;
    logic          sreq_q, sreq_d;
    logic          is_cmd;
    logic          is_idle;
    logic          expire;
    logic [15:0]   load_secs;
    logic          load_en;

    assign is_idle = cmd.valid && cmd.opcode == CMD_IDLE;
    assign is_cmd  = cmd.valid
                     && (cmd.opcode == CMD_IDLE || cmd.opcode == CMD_IDLE_IMM);
    assign expire  = run_q && mode_q == ISTC_IDLE && secs_q == 16'h0001
                     && tick_q == TW'(0);

    // timeout decode
    always_comb begin
        load_secs = 16'h0000;
        load_en   = 1'b1;
        if (cmd.count == CODE_OFF) begin
            load_en = 1'b0; // [RQ5]
        end else if (cmd.count <= CODE_SEC_MAX) begin
            load_secs = 16'(cmd.count) * 16'(SEC_UNIT_S); // [RQ7]
        end else if (cmd.count <= CODE_HALF_MAX) begin
            load_secs = 16'(cmd.count - 8'(HALF_BASE))
                        * 16'(HALF_UNIT_S); // [RQ8]
        end else if (cmd.count == CODE_21M) begin
            load_secs = UNITS_21M; // [RQ9]
        end else if (cmd.count == CODE_8H) begin
            load_secs = UNITS_8H; // [RQ9]
        end else if (cmd.count == CODE_21M15S) begin
            load_secs = UNITS_21M15S; // [RQ9]
        end else begin
            load_secs = UNITS_DEFAULT; // [RQ9]
        end
    end

    // command and timer next state
    always_comb begin
        mode_d = mode_q;
        secs_d = secs_q;
        tick_d = tick_q;
        run_d  = run_q;
        busy_d = 1'b0;
        irq_d  = 1'b0;
        spin_d = 1'b0;
        sreq_d = sreq_q && !standby_ack;
        if (run_q && mode_q == ISTC_IDLE) begin
            if (tick_q == TW'(0)) begin
                tick_d = TW'(TICK_CYC - 1);
                secs_d = secs_q - 16'h0001;
            end else begin
                tick_d = tick_q - TW'(1);
            end
        end
        if (expire) begin
            mode_d = ISTC_STANDBY; // [RQ6]
            run_d  = 1'b0;
            sreq_d = 1'b1; // [RQ6]
        end
        if (is_cmd) begin
            mode_d = ISTC_IDLE; // [RQ1] [RQ10]
            irq_d  = 1'b1; // [RQ2]
            busy_d = 1'b0; // [RQ1] [RQ10]
            spin_d = !spindle_on; // [RQ3]
            sreq_d = 1'b0;
        end
        if (is_idle) begin
            run_d  = load_en; // [RQ4] [RQ5]
            secs_d = load_secs; // [RQ11]
            tick_d = TW'(TICK_CYC - 1); // [RQ4]
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_q <= ISTC_ACTIVE;
            secs_q <= UNITS_DEFAULT;
            tick_q <= '0;
            run_q  <= 1'b0;
            busy_q <= 1'b0;
            irq_q  <= 1'b0;
            spin_q <= 1'b0;
            sreq_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            secs_q <= secs_d;
            tick_q <= tick_d;
            run_q  <= run_d;
            busy_q <= busy_d;
            irq_q  <= irq_d;
            spin_q <= spin_d;
            sreq_q <= sreq_d;
        end
    end

    assign resp.busy        = busy_q;
    assign resp.intrq       = irq_q;
    assign resp.spinup      = spin_q;
    assign resp.standby_req = sreq_q;
    assign mode             = mode_q;

    // checks
    sequence s_idle_cmd;
        cmd.valid && cmd.opcode == CMD_IDLE;
    endsequence

    sequence s_done;
        irq_q && !busy_q && mode_q == ISTC_IDLE;
    endsequence

    property p_idle_done;
        @(posedge core_clk) disable iff (!rst_b)
        s_idle_cmd |=> s_done;
    endproperty
    a_idle_done: assert property (p_idle_done) // [RQ1]
        else $error("idle command not completed");

    property p_imm_done;
        @(posedge core_clk) disable iff (!rst_b)
        (cmd.valid && cmd.opcode == CMD_IDLE_IMM) |=> s_done;
    endproperty
    a_imm_done: assert property (p_imm_done) // [RQ10]
        else $error("idle immediate not completed");

    property p_irq_early;
        @(posedge core_clk) disable iff (!rst_b)
        $rose(irq_q) |-> $past(is_cmd);
    endproperty
    a_irq_early: assert property (p_irq_early) // [RQ2]
        else $error("interrupt without command one cycle before");

    property p_no_spin;
        @(posedge core_clk) disable iff (!rst_b)
        (is_cmd && spindle_on) |=> !spin_q;
    endproperty
    a_no_spin: assert property (p_no_spin) // [RQ3]
        else $error("spin-up requested while spinning");

    property p_run_on;
        @(posedge core_clk) disable iff (!rst_b)
        (s_idle_cmd and (cmd.count != CODE_OFF)) |=> run_q
            ##1 (tick_q == TW'(TICK_CYC - 2));
    endproperty
    a_run_on: assert property (p_run_on) // [RQ4]
        else $error("timer not started");

    property p_run_off;
        @(posedge core_clk) disable iff (!rst_b)
        (s_idle_cmd and (cmd.count == CODE_OFF)) |=> !run_q && !sreq_q;
    endproperty
    a_run_off: assert property (p_run_off) // [RQ5]
        else $error("timer not disabled");

    property p_expire;
        @(posedge core_clk) disable iff (!rst_b)
        (expire && !is_cmd) |=> mode_q == ISTC_STANDBY && sreq_q;
    endproperty
    a_expire: assert property (p_expire) // [RQ6]
        else $error("no standby on expiry");

    property p_sec5;
        @(posedge core_clk) disable iff (!rst_b)
        (s_idle_cmd and (cmd.count == 8'h0c)) |=> secs_q == 16'd60;
    endproperty
    a_sec5: assert property (p_sec5) // [RQ7] [RQ11]
        else $error("five second code wrong");

    property p_half;
        @(posedge core_clk) disable iff (!rst_b)
        (s_idle_cmd and (cmd.count == 8'hf2)) |=> secs_q == 16'd3600;
    endproperty
    a_half: assert property (p_half) // [RQ8]
        else $error("thirty minute code wrong");

    property p_special;
        @(posedge core_clk) disable iff (!rst_b)
        (s_idle_cmd and (cmd.count == CODE_21M15S)) |=> secs_q == 16'd1275;
    endproperty
    a_special: assert property (p_special) // [RQ9]
        else $error("special code wrong");

    property p_sec_max;
        @(posedge core_clk) disable iff (!rst_b)
        (s_idle_cmd and (cmd.count == CODE_SEC_MAX)) |=> secs_q == 16'h04b0;
    endproperty
    a_sec_max: assert property (p_sec_max) // [RQ7]
        else $error("largest five second code wrong");

    property p_half_min;
        @(posedge core_clk) disable iff (!rst_b)
        (s_idle_cmd and (cmd.count == 8'hf1)) |=> secs_q == 16'h0708;
    endproperty
    a_half_min: assert property (p_half_min) // [RQ8]
        else $error("first thirty minute code wrong");

    property p_half_max;
        @(posedge core_clk) disable iff (!rst_b)
        (s_idle_cmd and (cmd.count == CODE_HALF_MAX)) |=> secs_q == 16'h4d58;
    endproperty
    a_half_max: assert property (p_half_max) // [RQ8]
        else $error("last thirty minute code wrong");

    property p_21m;
        @(posedge core_clk) disable iff (!rst_b)
        (s_idle_cmd and (cmd.count == CODE_21M)) |=> secs_q == 16'h04ec;
    endproperty
    a_21m: assert property (p_21m) // [RQ9]
        else $error("21 minute code wrong");

    property p_8h;
        @(posedge core_clk) disable iff (!rst_b)
        (s_idle_cmd and (cmd.count == CODE_8H)) |=> secs_q == 16'h7080;
    endproperty
    a_8h: assert property (p_8h) // [RQ9]
        else $error("8 hour code wrong");

    property p_rsvd;
        @(posedge core_clk) disable iff (!rst_b)
        (s_idle_cmd and (cmd.count == CODE_RSVD)) |=> secs_q == 16'h003c;
    endproperty
    a_rsvd: assert property (p_rsvd) // [RQ9]
        else $error("reserved code not one minute");

    property p_reload;
        @(posedge core_clk) disable iff (!rst_b)
        (s_idle_cmd and (run_q && cmd.count != CODE_OFF))
            |=> run_q && tick_q == TW'(TICK_CYC - 1);
    endproperty
    a_reload: assert property (p_reload) // [RQ11]
        else $error("running countdown not reloaded");

    property p_irq_pulse;
        @(posedge core_clk) disable iff (!rst_b)
        (irq_q && !is_cmd) |=> !irq_q;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) // [RQ2]
        else $error("interrupt longer than one cycle");

    property p_spin_up;
        @(posedge core_clk) disable iff (!rst_b)
        (is_cmd && !spindle_on) |=> spin_q;
    endproperty
    a_spin_up: assert property (p_spin_up) // [RQ3]
        else $error("no spin-up while stopped");

    sequence s_live;
        run_q && mode_q == ISTC_IDLE;
    endsequence

    property p_count;
        @(posedge core_clk) disable iff (!rst_b)
        (s_live and (tick_q != TW'(0) && !is_idle))
            |=> tick_q == $past(tick_q) - TW'(1);
    endproperty
    a_count: assert property (p_count) // [RQ4]
        else $error("timer not counting down");

    property p_stay_idle;
        @(posedge core_clk) disable iff (!rst_b)
        (mode_q == ISTC_IDLE && !run_q) |=> mode_q == ISTC_IDLE;
    endproperty
    a_stay_idle: assert property (p_stay_idle) // [RQ5]
        else $error("standby while timeout disabled");

    property p_sreq_hold;
        @(posedge core_clk) disable iff (!rst_b)
        (sreq_q && !standby_ack && !is_cmd) |=> sreq_q;
    endproperty
    a_sreq_hold: assert property (p_sreq_hold) // [RQ6]
        else $error("standby request dropped early");

    property p_standby_idle;
        @(posedge core_clk) disable iff (!rst_b)
        $rose(sreq_q) |-> $past(mode_q) == ISTC_IDLE && $past(run_q);
    endproperty
    a_standby_idle: assert property (p_standby_idle) // [RQ6]
        else $error("standby request without running idle timer");

    property p_imm_keep;
        @(posedge core_clk) disable iff (!rst_b)
        (is_cmd && !is_idle && !expire) |=> run_q == $past(run_q);
    endproperty
    a_imm_keep: assert property (p_imm_keep) // [RQ10]
        else $error("idle immediate changed timer enable");

endmodule // istc_top
`default_nettype wire

// >>> test/istc_host.sv
// host controller model issuing idle commands
`timescale 1ns/1ps
`default_nettype none
module istc_host (
    input  wire logic              core_clk,
    output istc_pkg::istc_cmd_type cmd,
    output logic                   spindle_on,
    output logic                   standby_ack
);
    import istc_pkg::*;
    initial begin
        cmd = '0;
        spindle_on = 1'b0;
        standby_ack = 1'b0;
    end
    task automatic lines(input logic sp, input logic ack);
        @(posedge core_clk);
        spindle_on <= sp;
        standby_ack <= ack;
    endtask
    // one-cycle strobe, then fields scrambled
    task automatic send(input logic [7:0] op, input logic [7:0] cnt);
        @(posedge core_clk);
        cmd <= '{valid: 1'b1, opcode: op, count: cnt};
        @(posedge core_clk);
        cmd <= '{valid: 1'b0, opcode: ~op, count: ~cnt};
    endtask
endmodule // istc_host
`default_nettype wire

// >>> test/istc_top_tb.sv
// bench for the idle and standby timer block
`timescale 1ns/1ps
`default_nettype none
module istc_top_tb;
    import istc_pkg::*;
    localparam int TCK = 4;
    logic                    core_clk = 1'b0;
    logic                    rst_b = 1'b0;
    istc_pkg::istc_cmd_type  cmd;
    logic                    spindle_on;
    logic                    standby_ack;
    istc_pkg::istc_resp_type resp;
    istc_pkg::istc_mode_type mode;
    int                      n_fail = 0;
    int                      tests_run = 0;
    logic [7:0]              codes [6] = '{8'h0c, 8'hf0, 8'hf1, 8'hfc,
                                           8'hff, 8'hfe};
    int                      secs [6] = '{60, 1200, 1800, 1260, 1275, 60};

    always #10 core_clk = ~core_clk;
    istc_host u_host (.core_clk(core_clk), .cmd(cmd),
        .spindle_on(spindle_on), .standby_ack(standby_ack));
    istc_top #(.TICK_CYC(TCK)) u_dut (.core_clk(core_clk), .rst_b(rst_b),
        .cmd(cmd), .spindle_on(spindle_on), .standby_ack(standby_ack),
        .resp(resp), .mode(mode));

    task automatic test_done;
        $display("checks %0d failures %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic chk_cyc(input string nm, input int e, input int g);
        tests_run++;
        if (g != e) begin
            n_fail++;
            $display("FAIL %s exp %0d got %0d", nm, e, g);
        end
    endtask
    // command, then completion checks one cycle later
    task automatic issue(input logic [7:0] op, input logic [7:0] c,
                         input logic sp);
        u_host.lines(sp, 1'b0);
        u_host.send(op, c);
        #1;
        chk("intrq", 8'h01, {7'h0, resp.intrq});
        chk("busy", 8'h00, {7'h0, resp.busy});
        chk("spinup", {7'h0, ~sp}, {7'h0, resp.spinup});
        chk("mode", {5'h0, ISTC_IDLE}, {5'h0, mode});
    endtask
    task automatic expire(input int e);
        int n;
        n = 0;
        while (resp.standby_req !== 1'b1 && n < e + 10) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk_cyc("period", e, n);
        chk("mode", {5'h0, ISTC_STANDBY}, {5'h0, mode});
        u_host.lines(1'b1, 1'b1);
        u_host.lines(1'b1, 1'b0);
        @(posedge core_clk);
        #1;
        chk("ack", 8'h00, {7'h0, resp.standby_req});
    endtask
    task automatic quiet(input int n);
        repeat (n) @(posedge core_clk);
        #1;
        chk("no_req", 8'h00, {7'h0, resp.standby_req});
        chk("mode", {5'h0, ISTC_IDLE}, {5'h0, mode});
    endtask

    initial begin
        #1200000;
        n_fail++;
        test_done();
    end
    initial begin
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        #1;
        chk("rst_mode", {5'h0, ISTC_ACTIVE}, {5'h0, mode});
        chk("rst_resp", 8'h00, {4'h0, resp});
        issue(CMD_IDLE, 8'h01, 1'b0);
        expire(5 * TCK);
        issue(CMD_IDLE, CODE_OFF, 1'b1);
        quiet(400);
        u_host.send(8'h90, 8'h01);
        #1;
        chk("ignored", 8'h00, {7'h0, resp.intrq});
        issue(CMD_IDLE, 8'h02, 1'b1);
        repeat (20) @(posedge core_clk);
        issue(CMD_IDLE, 8'h01, 1'b1);
        expire(5 * TCK);
        issue(CMD_IDLE_IMM, CODE_OFF, 1'b1);
        for (int i = 0; i < 6; i++) begin
            issue(CMD_IDLE, codes[i], 1'b1);
            expire(secs[i] * TCK);
        end
        issue(CMD_IDLE, 8'hf2, 1'b1);
        issue(CMD_IDLE, CODE_HALF_MAX, 1'b1);
        issue(CMD_IDLE, CODE_8H, 1'b1);
        quiet(5200);
        test_done();
    end
endmodule // istc_top_tb
`default_nettype wire
